// file: hw/nmt_pkg.sv
// constants and types for the network-management state machine
package nmt_pkg;

  // ==========================================================
  // frame format
  localparam logic [10:0] NMT_CAN_ID      = 11'h000;
  localparam logic [3:0]  NMT_FRAME_LEN   = 4'h2;
  localparam logic [6:0]  BROADCAST_NODE  = 7'h00;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_START       = 8'h01;
  localparam logic [7:0] CMD_STOP        = 8'h02;
  localparam logic [7:0] CMD_PREOP       = 8'h80;
  localparam logic [7:0] CMD_RESET_NODE  = 8'h81;
  localparam logic [7:0] CMD_RESET_COMM  = 8'h82;

  // ==========================================================
  // state report codes
  localparam logic [7:0] REPORT_INIT     = 8'h00;
  localparam logic [7:0] REPORT_STOPPED  = 8'h04;
  localparam logic [7:0] REPORT_OPER     = 8'h05;
  localparam logic [7:0] REPORT_PREOP    = 8'h7f;

  // ==========================================================
  // register table reset values
  localparam logic [31:0] MAX_SUBINDEX_RESET = 32'h0000_0002;
  localparam logic [31:0] EMCY_COUNT_RESET   = 32'h0000_0000;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned INIT_TIME_NS  = 1000;
  localparam int unsigned INIT_CYCLES   =
    (INIT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [3:0] {
    ST_INIT    = 4'b0001,
    ST_PREOP   = 4'b0010,
    ST_OPER    = 4'b0100,
    ST_STOPPED = 4'b1000
  } network_state_report_t;

endpackage : nmt_pkg

// file: hw/nmt_cmd_decode.sv
// decoder for two-byte network-management frames
`timescale 1ns/1ps
module nmt_cmd_decode (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // received frame
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic [3:0]  rx_len,
  input  wire logic [7:0]  rx_cmd,
  input  wire logic [7:0]  rx_node,
  input  wire logic [6:0]  own_node,
  // decoded command pulses
  output logic             go_start,
  output logic             go_stop,
  output logic             go_preop,
  output logic             go_reset
);

  logic hit;

  // anything else on the bus, or a frame of the wrong length, is not ours
  assign hit = rx_valid && (rx_id == nmt_pkg::NMT_CAN_ID)
            && (rx_len == nmt_pkg::NMT_FRAME_LEN)
            && ((rx_node == {1'b0, own_node})
             || (rx_node == {1'b0, nmt_pkg::BROADCAST_NODE}));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      go_start <= 1'b0;
      go_stop  <= 1'b0;
      go_preop <= 1'b0;
      go_reset <= 1'b0;
    end else begin
      go_start <= hit && (rx_cmd == nmt_pkg::CMD_START);
      go_stop  <= hit && (rx_cmd == nmt_pkg::CMD_STOP);
      go_preop <= hit && (rx_cmd == nmt_pkg::CMD_PREOP);
      go_reset <= hit && ((rx_cmd == nmt_pkg::CMD_RESET_NODE)
                       || (rx_cmd == nmt_pkg::CMD_RESET_COMM));
    end
  end

endmodule : nmt_cmd_decode

// file: hw/network_state_report_machine.sv
// network-management state machine with object gating and status values
`timescale 1ns/1ps
module network_state_report_machine #(
  parameter int unsigned INIT_CYCLES = nmt_pkg::INIT_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // received CAN frame
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic [3:0]  rx_len,
  input  wire logic [7:0]  rx_cmd,
  input  wire logic [7:0]  rx_node,
  input  wire logic [6:0]  own_node,
  // emergency transmit result
  input  wire logic        emcy_sent,
  // status registers
  output logic [31:0]      background_max_subindex,
  output logic [7:0]       network_state_report,
  output logic [31:0]      emergency_sent_counter,
  // communication object enables
  output logic             pdo_en,
  output logic             sdo_en,
  output logic             sync_en,
  output logic             emcy_en,
  output logic             nmt_en,
  output logic             heartbeat_en,
  output logic             bootup_en,
  output logic             pdo_build
);

  // ==========================================================
  // command decode
  logic go_start;
  logic go_stop;
  logic go_preop;
  logic go_reset;

  // pulses land one edge after the frame; the state moves on the next
  nmt_cmd_decode u_dec (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .rx_valid (rx_valid),
    .rx_id    (rx_id),
    .rx_len   (rx_len),
    .rx_cmd   (rx_cmd),
    .rx_node  (rx_node),
    .own_node (own_node),
    .go_start (go_start),
    .go_stop  (go_stop),
    .go_preop (go_preop),
    .go_reset (go_reset)
  );

  // ==========================================================
  // state decode helpers
  // one place decides each gate, so the enables cannot drift apart
  // process-data traffic exists only while operational
  function automatic logic pdo_state(input nmt_pkg::network_state_report_t s);
    case (s)
      nmt_pkg::ST_OPER: pdo_state = 1'b1;
      default:          pdo_state = 1'b0;
    endcase
  endfunction : pdo_state

  // sync, emergency and service data share one window
  function automatic logic service_state(input nmt_pkg::network_state_report_t s);
    case (s)
      nmt_pkg::ST_PREOP: service_state = 1'b1;
      nmt_pkg::ST_OPER:  service_state = 1'b1;
      default:           service_state = 1'b0;
    endcase
  endfunction : service_state

  // management and heartbeat stay up in every state but initialisation
  function automatic logic link_state(input nmt_pkg::network_state_report_t s);
    case (s)
      nmt_pkg::ST_PREOP:   link_state = 1'b1;
      nmt_pkg::ST_OPER:    link_state = 1'b1;
      nmt_pkg::ST_STOPPED: link_state = 1'b1;
      default:             link_state = 1'b0;
    endcase
  endfunction : link_state

  // ==========================================================
  // state machine
  // a command is taken only from the three running states
  // wide enough to hold INIT_CYCLES itself
  localparam int unsigned CW = $clog2(INIT_CYCLES + 1);

  nmt_pkg::network_state_report_t state_r;
  nmt_pkg::network_state_report_t state_nxt;
  logic [CW-1:0]       init_cnt_r;
  logic                init_done;

  assign init_done = (init_cnt_r == CW'(INIT_CYCLES - 1));

  // initialisation length is a stand-in for the boot work done elsewhere
  // count stops at its end value; leaving init clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_r <= '0;
    end else if (state_r != nmt_pkg::ST_INIT) begin
      init_cnt_r <= '0;
    end else if (!init_done) begin
      init_cnt_r <= init_cnt_r + CW'(1);
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      nmt_pkg::ST_INIT: begin
        // commands, resets too, are dropped until boot work ends
        if (init_done) begin
          state_nxt = nmt_pkg::ST_PREOP;
        end
      end
      nmt_pkg::ST_PREOP: begin
        // a second pre-op command changes nothing
        if (go_reset) begin
          state_nxt = nmt_pkg::ST_INIT;
        end else if (go_start) begin
          state_nxt = nmt_pkg::ST_OPER;
        end else if (go_stop) begin
          state_nxt = nmt_pkg::ST_STOPPED;
        end
      end
      nmt_pkg::ST_OPER: begin
        // a start while running changes nothing
        if (go_reset) begin
          state_nxt = nmt_pkg::ST_INIT;
        end else if (go_preop) begin
          state_nxt = nmt_pkg::ST_PREOP;
        end else if (go_stop) begin
          state_nxt = nmt_pkg::ST_STOPPED;
        end
      end
      nmt_pkg::ST_STOPPED: begin
        // only management frames reach this state's logic
        if (go_reset) begin
          state_nxt = nmt_pkg::ST_INIT;
        end else if (go_start) begin
          state_nxt = nmt_pkg::ST_OPER;
        end else if (go_preop) begin
          state_nxt = nmt_pkg::ST_PREOP;
        end
      end
      default: begin
        // an illegal code falls back to a fresh start
        state_nxt = nmt_pkg::ST_INIT;
      end
    endcase
  end

  // reset lands in initialisation at once, no command needed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= nmt_pkg::ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // object gating, registered so outputs come from flops
  // gates follow the next state so they move on the same edge as the report
  // stopped shuts everything but management and heartbeat
  // mapping may be edited in pre-operational without live traffic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pdo_en <= 1'b0;
    end else begin
      pdo_en <= pdo_state(state_nxt);
    end
  end

  // configuration path, open before and during operation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_en <= 1'b0;
    end else begin
      sdo_en <= service_state(state_nxt);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_en <= 1'b0;
    end else begin
      sync_en <= service_state(state_nxt);
    end
  end

  // emergencies are still counted while this gate is shut
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      emcy_en <= 1'b0;
    end else begin
      emcy_en <= service_state(state_nxt);
    end
  end

  // commands must reach a stopped node, or it could never leave
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nmt_en <= 1'b0;
    end else begin
      nmt_en <= link_state(state_nxt);
    end
  end

  // the master keeps supervising a stopped node
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      heartbeat_en <= 1'b0;
    end else begin
      heartbeat_en <= link_state(state_nxt);
    end
  end

  // boot-up message belongs to initialisation alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bootup_en <= 1'b0;
    end else begin
      bootup_en <= (state_nxt == nmt_pkg::ST_INIT);
    end
  end

  // ==========================================================
  // process-data build request
  // one-cycle request to rebuild process-data objects on entry
  // a return from stopped rebuilds too; staying operational does not
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pdo_build <= 1'b0;
    end else begin
      pdo_build <= pdo_state(state_nxt) && !pdo_state(state_r);
    end
  end

  // ==========================================================
  // state report
  // init has no code of its own; 0 keeps it apart from the reported three
  function automatic logic [7:0] report_code(input nmt_pkg::network_state_report_t s);
    case (s)
      nmt_pkg::ST_STOPPED: report_code = nmt_pkg::REPORT_STOPPED;
      nmt_pkg::ST_OPER:    report_code = nmt_pkg::REPORT_OPER;
      nmt_pkg::ST_PREOP:   report_code = nmt_pkg::REPORT_PREOP;
      nmt_pkg::ST_INIT:    report_code = nmt_pkg::REPORT_INIT;
      default:             report_code = nmt_pkg::REPORT_INIT;
    endcase
  endfunction : report_code

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      network_state_report <= nmt_pkg::REPORT_INIT;
    end else begin
      network_state_report <= report_code(state_nxt);
    end
  end

  // ==========================================================
  // emergency counter
  // counts in every state: a sent message is a fact regardless of gating
  // wraps silently after the full 32-bit range
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      emergency_sent_counter <= nmt_pkg::EMCY_COUNT_RESET;
    end else if (emcy_sent) begin
      emergency_sent_counter <= emergency_sent_counter + 32'h0000_0001;
    end
  end

  // ==========================================================
  // object dictionary constant
  // read-only, so the register just reloads its reset value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      background_max_subindex <= nmt_pkg::MAX_SUBINDEX_RESET;
    end else begin
      background_max_subindex <= nmt_pkg::MAX_SUBINDEX_RESET;
    end
  end

endmodule : network_state_report_machine

// file: verification/nmt_sm_sva.sv
// port-level assertions for the network-management state machine
`timescale 1ns/1ps
module nmt_sm_sva (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // frame and event inputs
  input wire logic        rx_valid,
  input wire logic        emcy_sent,
  input wire logic [10:0] rx_id,
  input wire logic [3:0]  rx_len,
  input wire logic [7:0]  rx_cmd,
  input wire logic [7:0]  rx_node,
  input wire logic [6:0]  own_node,
  // status and gates
  input wire logic [7:0]  network_state_report,
  input wire logic [31:0] emergency_sent_counter,
  input wire logic        pdo_en,
  input wire logic        sdo_en,
  input wire logic        sync_en,
  input wire logic        emcy_en,
  input wire logic        nmt_en,
  input wire logic        heartbeat_en,
  input wire logic        bootup_en,
  input wire logic        pdo_build
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ====
  // frames addressed here while not initialising
  sequence frame_ok;
    rx_valid && rx_id == 11'h000 && rx_len == 4'h2 && network_state_report != 8'h00 &&
    (rx_node == 8'h00 || rx_node == {1'b0, own_node});
  endsequence
  a_start_to_oper: assert property (frame_ok ##0 rx_cmd == 8'h01 |-> ##2
    network_state_report == 8'h05) else $error("start did not reach operational");
  a_preop_entry: assert property (frame_ok ##0 rx_cmd == 8'h80 |-> ##2
    network_state_report == 8'h7f) else $error("pre-op command not obeyed");
  a_stop_entry: assert property (frame_ok ##0 rx_cmd == 8'h02 |-> ##2
    network_state_report == 8'h04) else $error("stop command not obeyed");
  a_reset_to_init: assert property (frame_ok ##0 (rx_cmd == 8'h81 || rx_cmd == 8'h82) |-> ##2
    network_state_report == 8'h00) else $error("reset command not obeyed");
  a_init_exit: assert property ($fell(bootup_en) |-> network_state_report == 8'h7f)
    else $error("init left to wrong state");
  a_pdo_gate: assert property (pdo_en == (network_state_report == 8'h05))
    else $error("pdo gate wrong");
  a_service_gates: assert property ({sdo_en, sync_en, emcy_en} ==
    {3{network_state_report == 8'h7f || network_state_report == 8'h05}})
    else $error("service gates wrong");
  a_stop_quiet: assert property (network_state_report == 8'h04 |->
    nmt_en && heartbeat_en && !sdo_en && !sync_en && !emcy_en && !pdo_en)
    else $error("stopped node not quiet");
  a_build_entry: assert property (pdo_build ==
    (network_state_report == 8'h05 && $past(network_state_report) != 8'h05))
    else $error("pdo build not on entry");
  a_emcy_step: assert property (emcy_sent |=>
    emergency_sent_counter == $past(emergency_sent_counter) + 32'h1)
    else $error("emergency count missed");
  a_emcy_hold: assert property (!emcy_sent |=> $stable(emergency_sent_counter))
    else $error("emergency count moved");
endmodule : nmt_sm_sva
bind network_state_report_machine nmt_sm_sva u_sva (.mclk, .rst_n, .rx_valid, .emcy_sent, .rx_id,
  .rx_len, .rx_cmd, .rx_node, .own_node, .network_state_report, .emergency_sent_counter,
  .pdo_en, .sdo_en, .sync_en, .emcy_en, .nmt_en, .heartbeat_en, .bootup_en, .pdo_build);

// file: verification/nmt_master_model.sv
// network master model: presents management frames on the receive port
`timescale 1ns/1ps
module nmt_master_model (
  // clock
  input wire logic    mclk,
  // frame towards the node
  output logic        rx_valid,
  output logic [10:0] rx_id,
  output logic [3:0]  rx_len,
  output logic [7:0]  rx_cmd,
  output logic [7:0]  rx_node
);
  initial begin
    rx_valid = 1'b0;
    {rx_id, rx_len, rx_cmd, rx_node} = '0;
  end
  // ====
  // one frame per call
  task send(input logic [7:0] cmd, input logic [7:0] node,
            input logic [10:0] id, input logic [3:0] len);
    @(posedge mclk);
    #1;
    rx_valid = 1'b1;
    {rx_id, rx_len} = {id, len};
    {rx_cmd, rx_node} = {cmd, node};
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    // inverted so a stale field never looks like a fresh frame
    {rx_id, rx_len, rx_cmd, rx_node} = ~{id, len, cmd, node};
  endtask : send
endmodule : nmt_master_model

// file: verification/network_management_state_machine_tb.sv
// self-checking bench for the network-management state machine
`timescale 1ns/1ps
module network_management_state_machine_tb;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        emcy_sent = 1'b0;
  logic [6:0]  own_node = 7'h05;
  logic        rx_valid;
  logic [10:0] rx_id;
  logic [3:0]  rx_len;
  logic [7:0]  rx_cmd, rx_node, rpt;
  logic [31:0] max_sub, cnt;
  logic        pdo_en, sdo_en, sync_en, emcy_en, nmt_en, hb_en, boot_en, pdo_build;
  logic [31:0] gates;
  int          n_fail = 0;
  int          checks = 0;
  always #12.5 mclk = ~mclk;
  nmt_master_model mst (.mclk, .rx_valid, .rx_id, .rx_len, .rx_cmd, .rx_node);
  network_state_report_machine #(.INIT_CYCLES(2)) dut (.mclk, .rst_n, .rx_valid, .rx_id, .rx_len,
    .rx_cmd, .rx_node, .own_node, .emcy_sent, .background_max_subindex(max_sub),
    .network_state_report(rpt), .emergency_sent_counter(cnt), .pdo_en, .sdo_en,
    .sync_en, .emcy_en, .nmt_en, .heartbeat_en(hb_en), .bootup_en(boot_en), .pdo_build);
  assign gates = {26'h0, sdo_en, sync_en, emcy_en, nmt_en, hb_en, boot_en};
  // ====
  // checks and sequencing
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  // expected {sdo, sync, emcy, nmt, heartbeat, boot-up} per reported state
  function automatic logic [31:0] gates_for(input logic [7:0] code);
    case (code)
      8'h05:   gates_for = 32'h0000_003e;
      8'h7f:   gates_for = 32'h0000_003e;
      8'h04:   gates_for = 32'h0000_0006;
      default: gates_for = 32'h0000_0001;
    endcase
  endfunction : gates_for
  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task wait_preop;
    int i;
    for (i = 0; i < 50 && rpt !== 8'h7f; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("init exit", 32'h7f, {24'h0, rpt});
    chk("preop gates", 32'h3e, gates);
    if (i == 50) stop_test;
  endtask : wait_preop
  task step(input logic [7:0] c, input logic [7:0] n, input logic [7:0] exp,
            input logic [10:0] id = 11'h000, input logic [3:0] len = 4'h2);
    logic was_oper;
    was_oper = (rpt === 8'h05);
    mst.send(c, n, id, len);
    // pdo_build stands one cycle only, so look right after it rises
    @(posedge mclk);
    #1;
    chk("state report", {24'h0, exp}, {24'h0, rpt});
    chk("gates", gates_for(exp), gates);
    chk("pdo gate", {31'h0, exp == 8'h05}, {31'h0, pdo_en});
    chk("pdo build", {31'h0, exp == 8'h05 && !was_oper}, {31'h0, pdo_build});
  endtask : step
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    chk("max subindex", 32'h2, max_sub);
    rst_n = 1'b1;
    chk("init report", 32'h0, {24'h0, rpt});
    wait_preop;
    step(8'h02, 8'h05, 8'h04);
    step(8'h01, 8'h05, 8'h05);
    step(8'h80, 8'h05, 8'h7f);
    step(8'h01, 8'h00, 8'h05);
    step(8'h02, 8'h05, 8'h04);
    step(8'h80, 8'h05, 8'h7f);
    step(8'h01, 8'h05, 8'h05);
    step(8'h02, 8'h09, 8'h05);
    step(8'h02, 8'h85, 8'h05);
    step(8'h02, 8'h05, 8'h05, 11'h001);
    step(8'h02, 8'h05, 8'h05, 11'h000, 4'h3);
    step(8'h03, 8'h05, 8'h05);
    step(8'h01, 8'h05, 8'h05);
    step(8'h81, 8'h05, 8'h00);
    wait_preop;
    step(8'h02, 8'h00, 8'h04);
    step(8'h82, 8'h05, 8'h00);
    wait_preop;
    step(8'h82, 8'h00, 8'h00);
    wait_preop;
    own_node = 7'h09;
    step(8'h02, 8'h09, 8'h04);
    step(8'h01, 8'h05, 8'h04);
    emcy_sent = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    emcy_sent = 1'b0;
    @(posedge mclk);
    #1;
    chk("emergency count", 32'h2, cnt);
    rst_n = 1'b0;
    #1;
    chk("reset clears", 32'h0, {cnt[23:0], rpt});
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    wait_preop;
    stop_test;
  end
endmodule : network_management_state_machine_tb
